/* File: pkg/diag_pkg.sv */
package diag_pkg;
  // frame geometry
  localparam int FRAME_BITS = 16;
  localparam int BYTE_BITS  = 8;
  localparam int CNT_W      = 5;
  localparam logic [CNT_W-1:0] CNT_FRAME = 5'h10;
  localparam logic [CNT_W-1:0] CNT_BYTE  = 5'h08;
  localparam logic [CNT_W-1:0] CNT_OVER  = 5'h11;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;

  // address byte layout: bit 7 selects clear, bits 6..0 the register
  localparam int OP_BIT   = 15;
  localparam int ADDR_HI  = 14;
  localparam int ADDR_LO  = 8;
  localparam logic [6:0] STATUS_ADDR = 7'h19;

  // global status byte layout
  localparam int SPI_ERR_BIT = 7;
  localparam int LOAD_BIT    = 6;
  localparam int UV_BIT      = 5;
  localparam int OV_BIT      = 4;
  localparam int NO_POWER_UP_FLAG_BIT    = 3;
  localparam int TSD_BIT     = 2;
  localparam int TPW_BIT     = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] NO_POWER_UP_FLAG_MASK    = 8'h08;

  // power outputs and monitored pins
  localparam int LOAD_N = 12;
  localparam int PIN_W  = 3 + 4 + 2 * LOAD_N;
  localparam logic [PIN_W-1:0] PIN_INIT = 31'h2000_0000;

  // frame state
  typedef enum logic {ST_IDLE, ST_FRAME} frame_state_t;
endpackage

/* File: design/input_sync.sv */
`timescale 1ns/100ps
module input_sync #(
  parameter int            W    = 1,
  parameter logic [W-1:0]  INIT = '0
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // raw pins and filtered result
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;
  logic [W-1:0] dout_next;

  // a bit moves only once stages two and three agree
  always_comb begin
    dout_next = (ff2_reg & ~(ff2_reg ^ ff3_reg)) | (dout & (ff2_reg ^ ff3_reg));
  end

  // three stages; first is only read by the second
  always_ff @(posedge clock) begin
    if (rst) begin
      ff1_reg <= INIT;
      ff2_reg <= INIT;
      ff3_reg <= INIT;
      dout    <= INIT;
    end else begin
      ff1_reg <= din;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      dout    <= dout_next;
    end
  end
endmodule

/* File: design/global_diag_status_bank.sv */
// Contract
// - all status bits read zero after reset.
// - a frame is sixteen bits: address byte, then data byte.
// - address bit 7 low reads the register without changing it.
// - address bit 7 high clears the addressed register as a byte.
// - latched flags never clear by themselves, only by command.
// - bit 7 latches on a bad frame length.
// - bit 6 reads the OR of all latched load faults.
// - overcurrent latches the fault and keeps that output off.
// - bit 5 latches undervoltage; all outputs off while set.
// - bit 4 latches overvoltage; all outputs off while set.
// - bit 3 reads zero after power-up reset, one once a clear command has run.
// - bit 2 latches thermal shutdown and disables all outputs.
// - bit 1 latches thermal pre-warning.
`timescale 1ns/100ps
module global_diag_status_bank (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // spi pins
  input  wire logic                        sclk,
  input  wire logic                        cs_n,
  input  wire logic                        mosi,
  output logic                             miso,
  output logic                             miso_oe_n,
  // analogue monitors, asynchronous levels
  input  wire logic                        supply_uv,
  input  wire logic                        supply_ov,
  input  wire logic                        temp_shutdown,
  input  wire logic                        temp_prewarn,
  input  wire logic [diag_pkg::LOAD_N-1:0] open_load,
  input  wire logic [diag_pkg::LOAD_N-1:0] over_current,
  // per-output fault clear, same clock
  input  wire logic [diag_pkg::LOAD_N-1:0] load_fault_clear,
  // power stage switch-off
  output logic      [diag_pkg::LOAD_N-1:0] out_disable
);
  import diag_pkg::*;

  logic [PIN_W-1:0]  pins_raw;
  logic [PIN_W-1:0]  pins_s;
  logic              sclk_s;
  logic              cs_n_s;
  logic              mosi_s;
  logic              uv_s;
  logic              ov_s;
  logic              tsd_s;
  logic              tpw_s;
  logic [LOAD_N-1:0] ol_s;
  logic [LOAD_N-1:0] oc_s;

  // all pins come from outside the clock domain
  assign pins_raw = {sclk, cs_n, mosi, supply_uv, supply_ov,
                     temp_shutdown, temp_prewarn, open_load, over_current};

  input_sync #(
    .W    (PIN_W),
    .INIT (PIN_INIT)
  ) input_sync_i (
    .clock (clock),
    .rst   (rst),
    .din   (pins_raw),
    .dout  (pins_s)
  );

  assign {sclk_s, cs_n_s, mosi_s, uv_s, ov_s, tsd_s, tpw_s, ol_s, oc_s} =
    pins_s;

  // spi frame state
  frame_state_t     state_reg;
  frame_state_t     state_next;
  logic             sclk_q_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [15:0]      rx_reg;
  logic [15:0]      rx_next;
  logic [7:0]       tx_reg;
  logic [7:0]       tx_next;
  logic             miso_next;
  logic             miso_oe_n_next;
  logic             frame_end;
  logic             rise;
  logic             fall;
  logic [7:0]       status_byte;
  logic [7:0]       reply;

  assign rise = sclk_s & ~sclk_q_reg;
  assign fall = ~sclk_s & sclk_q_reg;

  // second byte answers only for this register
  assign reply = (rx_reg[6:0] == STATUS_ADDR) ? status_byte : STATUS_RESET;

  // mode 0: sample on rise, shift out on fall
  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    rx_next        = rx_reg;
    tx_next        = tx_reg;
    miso_next      = miso;
    miso_oe_n_next = miso_oe_n;
    frame_end      = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (!cs_n_s) begin
          state_next     = ST_FRAME;
          cnt_next       = CNT_ZERO;
          rx_next        = '0;
          miso_next      = status_byte[7];
          tx_next        = {status_byte[6:0], 1'b0};
          miso_oe_n_next = 1'b0;
        end
      end
      ST_FRAME: begin
        if (cs_n_s) begin
          state_next     = ST_IDLE;
          frame_end      = 1'b1;
          miso_next      = 1'b0;
          miso_oe_n_next = 1'b1;
        end else if (rise) begin
          rx_next = {rx_reg[14:0], mosi_s};
          // saturate so long frames still count as bad
          if (cnt_reg != CNT_OVER) begin
            cnt_next = cnt_reg + CNT_ONE;
          end
        end else if (fall) begin
          if (cnt_reg == CNT_BYTE) begin
            miso_next = reply[7];
            tx_next   = {reply[6:0], 1'b0};
          end else begin
            miso_next = tx_reg[7];
            tx_next   = {tx_reg[6:0], 1'b0};
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      sclk_q_reg <= 1'b0;
      cnt_reg    <= CNT_ZERO;
      rx_reg     <= '0;
      tx_reg     <= STATUS_RESET;
      miso       <= 1'b0;
      miso_oe_n  <= 1'b1;
    end else begin
      state_reg  <= state_next;
      sclk_q_reg <= sclk_s;
      cnt_reg    <= cnt_next;
      rx_reg     <= rx_next;
      tx_reg     <= tx_next;
      miso       <= miso_next;
      miso_oe_n  <= miso_oe_n_next;
    end
  end

  // status flags and load latches
  logic              frame_bad;
  logic              clear_cmd;
  logic [7:0]        set_vec;
  logic [7:0]        flags_reg;
  logic [7:0]        flags_next;
  logic [LOAD_N-1:0] oc_reg;
  logic [LOAD_N-1:0] oc_next;
  logic [LOAD_N-1:0] ol_reg;
  logic [LOAD_N-1:0] ol_next;
  logic              lfs_reg;
  logic              lfs_next;
  logic [LOAD_N-1:0] out_disable_next;

  assign frame_bad = frame_end && (cnt_reg != CNT_FRAME);
  assign clear_cmd = frame_end && (cnt_reg == CNT_FRAME)
                     && rx_reg[OP_BIT]
                     && (rx_reg[ADDR_HI:ADDR_LO] == STATUS_ADDR);
  assign status_byte = flags_reg | ({7'h00, lfs_reg} << LOAD_BIT);

  // events win over a clear in the same cycle
  always_comb begin
    set_vec              = STATUS_RESET;
    set_vec[SPI_ERR_BIT] = frame_bad;
    set_vec[UV_BIT]      = uv_s;
    set_vec[OV_BIT]      = ov_s;
    set_vec[TSD_BIT]     = tsd_s;
    set_vec[TPW_BIT]     = tpw_s;
    // a plain read leaves the flags; only a clear drops them
    flags_next = flags_reg;
    if (clear_cmd) begin
      flags_next = NO_POWER_UP_FLAG_MASK;
    end
    flags_next = flags_next | set_vec;
    // load summary ignores the clear command
    oc_next  = (oc_reg & ~load_fault_clear) | oc_s;
    ol_next  = (ol_reg & ~load_fault_clear) | ol_s;
    lfs_next = |(oc_next | ol_next);
    // supply or thermal faults switch every output off
    out_disable_next = oc_next | {LOAD_N{flags_next[UV_BIT]
      | flags_next[OV_BIT] | flags_next[TSD_BIT]}};
  end

  // power-up reset is the only reset; no_power_up_flag then reads zero
  always_ff @(posedge clock) begin
    if (rst) begin
      flags_reg   <= STATUS_RESET;
      oc_reg      <= '0;
      ol_reg      <= '0;
      lfs_reg     <= 1'b0;
      out_disable <= '0;
    end else begin
      flags_reg   <= flags_next;
      oc_reg      <= oc_next;
      ol_reg      <= ol_next;
      lfs_reg     <= lfs_next;
      out_disable <= out_disable_next;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seq_open;
    (state_reg == ST_IDLE) && !cs_n_s;
  endsequence

  sequence seq_quiet_clear;
    clear_cmd && (set_vec == STATUS_RESET);
  endsequence

  sequence seq_plain_read;
    frame_end && !clear_cmd && (set_vec == STATUS_RESET);
  endsequence

  reset_zero_a: assert property ($past(rst) |-> status_byte == STATUS_RESET)
    else $error("status not zero after reset");
  frame_drive_a: assert property (seq_open |=> !miso_oe_n ##0
    (cnt_reg == CNT_ZERO)) else $error("frame start missed");
  read_keep_a: assert property (seq_plain_read |=>
    flags_reg == $past(flags_reg)) else $error("read changed flags");
  clear_byte_a: assert property (seq_quiet_clear |=>
    flags_reg == NO_POWER_UP_FLAG_MASK) else $error("clear did not clear");
  flag_hold_a: assert property (!clear_cmd |=>
    (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("flag dropped on its own");
  spi_err_a: assert property (frame_bad |=> flags_reg[SPI_ERR_BIT])
    else $error("bad frame not flagged");
  load_or_a: assert property (status_byte[LOAD_BIT] == |(oc_reg | ol_reg))
    else $error("load summary wrong");
  oc_off_a: assert property ((oc_reg & ~out_disable) == '0)
    else $error("faulty output left on");
  supply_off_a: assert property ((flags_reg[UV_BIT] | flags_reg[OV_BIT]
    | flags_reg[TSD_BIT]) |-> &out_disable)
    else $error("outputs on during fault");
  prewarn_set_a: assert property (tpw_s |=> flags_reg[TPW_BIT] [*1])
    else $error("prewarning not latched");
  summary_keep_a: assert property (clear_cmd && lfs_reg
    && (load_fault_clear == '0) |=> lfs_reg)
    else $error("clear touched load summary");
endmodule

/* File: tb/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
  // clock
  input  wire logic clock,
  // spi pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe_n
);
  logic line;

  // idle bus: deselected, clock low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    line = 1'b0;
  end

  // msb-first frame of n bits, mode 0; 8-clock half period
  // leaves room for the device's input synchroniser
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clock);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = tx[15-i];
      repeat (8) @(negedge clock);
      // an undriven line shows the inverse of its last level
      line = miso_oe_n ? ~line : miso;
      rx = {rx[14:0], line};
      sclk = 1'b1;
      repeat (8) @(negedge clock);
      sclk = 1'b0;
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    repeat (12) @(negedge clock);
  endtask
endmodule

/* File: tb/tb_global_diag_status_bank.sv */
`timescale 1ns/100ps
module tb_global_diag_status_bank;
  import diag_pkg::*;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              sclk, cs_n, mosi, miso, miso_oe_n;
  logic [3:0]        ev = 4'h0;
  logic [LOAD_N-1:0] open_load = '0;
  logic [LOAD_N-1:0] over_current = '0;
  logic [LOAD_N-1:0] load_fault_clear = '0;
  logic [LOAD_N-1:0] out_disable;
  logic [15:0]       rx;
  logic [7:0]        st;
  logic [7:0]        evbit [4] = '{8'h20, 8'h10, 8'h04, 8'h02};
  int                n_fail = 0;
  int                comparisons = 0;
  int                cycles = 0;

  // 20 mhz clock
  always #25 clock = ~clock;

  global_diag_status_bank global_diag_status_bank_i (
    .clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe_n(miso_oe_n), .supply_uv(ev[3]),
    .supply_ov(ev[2]), .temp_shutdown(ev[1]), .temp_prewarn(ev[0]),
    .open_load(open_load), .over_current(over_current),
    .load_fault_clear(load_fault_clear), .out_disable(out_disable));

  spi_host_model spi_host_model_i (
    .clock(clock), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe_n(miso_oe_n));

  task automatic end_of_test;
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard, well above the ~7500 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one frame; the reply shows the status from before any clear
  task automatic acc(input logic op, input logic [6:0] a);
    spi_host_model_i.frame({op, a, 8'h00}, 16, rx);
    check(rx, {st, (a == STATUS_ADDR) ? st : 8'h00});
    if (op && a == STATUS_ADDR)
      st = NO_POWER_UP_FLAG_MASK | (st & 8'h40);
  endtask

  // hold monitor pins long enough to pass the synchroniser
  task automatic stim(input logic [3:0] e, input logic [LOAD_N-1:0] o,
                      input logic [LOAD_N-1:0] c, input logic [LOAD_N-1:0] k);
    @(negedge clock);
    ev = e;
    open_load = o;
    over_current = c;
    load_fault_clear = k;
    repeat (10) @(negedge clock);
    ev = 4'h0;
    open_load = '0;
    over_current = '0;
    load_fault_clear = '0;
    repeat (10) @(negedge clock);
  endtask

  // main sequence
  initial begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    st = STATUS_RESET;
    acc(1'b0, STATUS_ADDR);
    check({14'h0000, miso_oe_n, miso}, 16'h0002);
    acc(1'b1, STATUS_ADDR);
    acc(1'b0, STATUS_ADDR);
    // each supply and thermal event, latched after the pin drops
    for (int i = 0; i < 4; i++) begin
      stim(4'h8 >> i, '0, '0, '0);
      st = st | evbit[i];
      acc(1'b0, STATUS_ADDR);
      check({4'h0, out_disable}, (i < 3) ? 16'h0fff : 16'h0000);
      acc(1'b0, STATUS_ADDR);
      acc(1'b1, STATUS_ADDR);
      check({4'h0, out_disable}, 16'h0000);
    end
    // overcurrent on output 3: summary set, output held off
    stim(4'h0, '0, 12'h008, '0);
    st = st | 8'h40;
    acc(1'b0, STATUS_ADDR);
    check({4'h0, out_disable}, 16'h0008);
    acc(1'b1, STATUS_ADDR);
    acc(1'b0, STATUS_ADDR);
    check({4'h0, out_disable}, 16'h0008);
    stim(4'h0, '0, '0, 12'h008);
    st = NO_POWER_UP_FLAG_MASK;
    acc(1'b0, STATUS_ADDR);
    // open load on output 5 only feeds the summary
    stim(4'h0, 12'h020, '0, '0);
    st = st | 8'h40;
    acc(1'b0, STATUS_ADDR);
    check({4'h0, out_disable}, 16'h0000);
    stim(4'h0, '0, '0, 12'h020);
    st = NO_POWER_UP_FLAG_MASK;
    // short frame, then a clear aimed at another address
    spi_host_model_i.frame({1'b1, STATUS_ADDR, 8'h00}, 15, rx);
    check({8'h00, rx[14:7]}, {8'h00, st});
    st = st | 8'h80;
    acc(1'b0, STATUS_ADDR);
    acc(1'b1, 7'h10);
    acc(1'b0, STATUS_ADDR);
    acc(1'b1, STATUS_ADDR);
    acc(1'b0, STATUS_ADDR);
    // latch a supply fault so the reset below has state to drop
    stim(4'h8, '0, '0, '0);
    // power-on reset in mid-run
    @(negedge clock);
    rst = 1'b1;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    st = STATUS_RESET;
    check({4'h0, out_disable}, 16'h0000);
    acc(1'b0, STATUS_ADDR);
    end_of_test();
  end
endmodule
